// file: rtl/itd_core.sv
// module: instruction fetch and timing sequencer with an AXI4-Lite register slave
//
// Chosen here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module itd_core
#(
    parameter int CYCLE_CLKS = itd_pkg::MACHINE_CYCLE_CLKS
)
(
    // clock, reset, enable
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    // axi4-lite write address and data
    input wire logic [itd_pkg::AXI_AW-1:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [itd_pkg::AXI_DW-1:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    // axi4-lite read
    input wire logic [itd_pkg::AXI_AW-1:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [itd_pkg::AXI_DW-1:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    // program memory, one clock read latency
    output logic [itd_pkg::PC_W-1:0] pm_addr_out,
    output logic pm_rd_out,
    input wire logic [7:0] pm_data_in,
    // completion pulse
    output logic instr_done_out
);
    import itd_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // declarations

    itd_dec_if dif();
    itd_state_t state_q;
    logic mc_tick;
    logic run_q;
    logic illegal_q;
    logic [PC_W-1:0] pc_q;
    logic [7:0] opcode_q;
    logic [7:0] arg_q;
    logic two_bytes_q;
    logic two_cycles_q;
    itd_class_t cls_q;
    logic [1:0] cyc_left_q;
    logic [CNT_W-1:0] instr_cnt_q;
    logic [CNT_W-1:0] cycle_cnt_q;
    logic [AXI_AW-1:0] waddr_q;
    logic [AXI_DW-1:0] wdata_q;
    logic [3:0] wstrb_q;
    logic aw_have_q;
    logic w_have_q;

    ////////////////////////////////////////////////////////////////////////
    // sub-blocks

    // machine cycle tick
    itd_mc_timer #(.CYCLE_CLKS(CYCLE_CLKS)) u_timer
    (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .ce_in(ce_in),
        .tick_out(mc_tick)
    );

    // opcode decode
    itd_decoder u_dec
    (
        .dec(dif.dec)
    );

    assign dif.opcode = opcode_q;

    ////////////////////////////////////////////////////////////////////////
    // register write decode

    // a write fires once both address and data are held and no response is pending
    wire wr_fire = aw_have_q && w_have_q && !s_axi_bvalid_out;
    wire wr_hit_ctrl = (waddr_q == REG_CTRL);
    wire wr_hit_pc = (waddr_q == REG_PC);
    wire wr_hit_status = (waddr_q == REG_STATUS);
    wire wr_mapped = wr_hit_ctrl || wr_hit_pc || wr_hit_status;

    // byte-lane mask from the write strobes
    wire [AXI_DW-1:0] lane_mask;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_lane
            assign lane_mask[gi*8 +: 8] = {8{wstrb_q[gi]}};
        end
    endgenerate

    // merged words for the control and program counter registers
    wire [AXI_DW-1:0] ctrl_word = {{(AXI_DW-1){1'b0}}, run_q};
    wire [AXI_DW-1:0] ctrl_new = (ctrl_word & ~lane_mask) | (wdata_q & lane_mask);
    wire [AXI_DW-1:0] pc_word = {{(AXI_DW-PC_W){1'b0}}, pc_q};
    wire [AXI_DW-1:0] pc_new = (pc_word & ~lane_mask) | (wdata_q & lane_mask);
    wire illegal_clr = wr_fire && wr_hit_status && wstrb_q[0] && wdata_q[STAT_ILLEGAL_BIT];
    // the program counter may be loaded only while the sequencer is idle
    wire pc_load = wr_fire && wr_hit_pc && (state_q == ST_IDLE);

    ////////////////////////////////////////////////////////////////////////
    // register read decode

    wire [AXI_DW-1:0] status_word = {{(AXI_DW-STAT_CLASS_LSB-5){1'b0}}, cls_q, 4'h0,
        two_cycles_q, two_bytes_q, illegal_q, (state_q != ST_IDLE)};
    wire [AXI_DW-1:0] last_word = {{(AXI_DW-16){1'b0}}, arg_q, opcode_q};
    wire rd_hit_ctrl = (s_axi_araddr_in == REG_CTRL);
    wire rd_hit_pc = (s_axi_araddr_in == REG_PC);
    wire rd_hit_status = (s_axi_araddr_in == REG_STATUS);
    wire rd_hit_last = (s_axi_araddr_in == REG_LAST);
    wire rd_hit_icnt = (s_axi_araddr_in == REG_INSTR_CNT);
    wire rd_hit_ccnt = (s_axi_araddr_in == REG_CYCLE_CNT);
    wire rd_mapped = rd_hit_ctrl || rd_hit_pc || rd_hit_status || rd_hit_last || rd_hit_icnt || rd_hit_ccnt;
    wire [AXI_DW-1:0] rd_word =
        rd_hit_ctrl ? ctrl_word :
        rd_hit_pc ? pc_word :
        rd_hit_status ? status_word :
        rd_hit_last ? last_word :
        rd_hit_icnt ? instr_cnt_q :
        rd_hit_ccnt ? cycle_cnt_q : '0;

    ////////////////////////////////////////////////////////////////////////
    // axi4-lite write channels

    // address and data are taken in either order, response follows both
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            waddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= 4'h0;
            s_axi_awready_out <= 1'b1;
            s_axi_wready_out <= 1'b1;
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out <= RESP_OKAY;
        end
        else if (ce_in)
        begin
            if (s_axi_awvalid_in && s_axi_awready_out)
            begin
                aw_have_q <= 1'b1;
                waddr_q <= s_axi_awaddr_in;
                s_axi_awready_out <= 1'b0;
            end
            if (s_axi_wvalid_in && s_axi_wready_out)
            begin
                w_have_q <= 1'b1;
                wdata_q <= s_axi_wdata_in;
                wstrb_q <= s_axi_wstrb_in;
                s_axi_wready_out <= 1'b0;
            end
            if (wr_fire)
            begin
                s_axi_bvalid_out <= 1'b1;
                s_axi_bresp_out <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid_out && s_axi_bready_in)
            begin
                s_axi_bvalid_out <= 1'b0;
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_axi_awready_out <= 1'b1;
                s_axi_wready_out <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // axi4-lite read channels

    // data is captured with the address, answered one clock later
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            s_axi_arready_out <= 1'b1;
            s_axi_rvalid_out <= 1'b0;
            s_axi_rdata_out <= '0;
            s_axi_rresp_out <= RESP_OKAY;
        end
        else if (ce_in)
        begin
            if (s_axi_arvalid_in && s_axi_arready_out)
            begin
                s_axi_arready_out <= 1'b0;
                s_axi_rvalid_out <= 1'b1;
                s_axi_rdata_out <= rd_word;
                s_axi_rresp_out <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_rvalid_out && s_axi_rready_in)
            begin
                s_axi_rvalid_out <= 1'b0;
                s_axi_arready_out <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control register and sticky flag

    // undefined opcode flag: hardware set beats a software clear
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            run_q <= RUN_RESET;
            illegal_q <= 1'b0;
        end
        else if (ce_in)
        begin
            if (wr_fire && wr_hit_ctrl)
                run_q <= ctrl_new[CTRL_RUN_BIT];
            if (state_q == ST_DECODE && !dif.defined)
                illegal_q <= 1'b1;
            else if (illegal_clr)
                illegal_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer helpers

    // instruction completes on the tick that ends its last machine cycle
    wire exec_last = (state_q == ST_EXEC) && mc_tick && (cyc_left_q == 2'd1);
    wire [PC_W-1:0] pc_next = pc_q + (two_bytes_q ? PC_W'(2) : PC_W'(1));
    wire [1:0] cycles_dec = dif.two_cycles ? 2'd2 : 2'd1;

    ////////////////////////////////////////////////////////////////////////
    // fetch and execute sequencer

    // fetch opcode at a cycle start, fetch second byte, then count machine cycles
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            state_q <= ST_IDLE;
            pc_q <= PC_RESET;
            opcode_q <= 8'h00;
            arg_q <= 8'h00;
            two_bytes_q <= 1'b0;
            two_cycles_q <= 1'b0;
            cls_q <= CL_NOP;
            cyc_left_q <= 2'd0;
            pm_addr_out <= PC_RESET;
            pm_rd_out <= 1'b0;
            instr_done_out <= 1'b0;
        end
        else if (ce_in)
        begin
            instr_done_out <= 1'b0;
            pm_rd_out <= 1'b0;
            case (state_q)
                ST_IDLE:
                begin
                    if (pc_load)
                        pc_q <= pc_new[PC_W-1:0];
                    else if (run_q && mc_tick)
                    begin
                        pm_addr_out <= pc_q;
                        pm_rd_out <= 1'b1;
                        state_q <= ST_OP_WAIT;
                    end
                end
                ST_OP_WAIT:
                    state_q <= ST_OP_CAP;
                ST_OP_CAP:
                begin
                    opcode_q <= pm_data_in;
                    state_q <= ST_DECODE;
                end
                ST_DECODE:
                begin
                    two_bytes_q <= dif.two_bytes;
                    two_cycles_q <= dif.two_cycles;
                    cls_q <= dif.cls;
                    cyc_left_q <= cycles_dec;
                    if (dif.two_bytes)
                    begin
                        pm_addr_out <= pc_q + PC_W'(1);
                        pm_rd_out <= 1'b1;
                        state_q <= ST_ARG_WAIT;
                    end
                    else
                    begin
                        arg_q <= 8'h00;
                        state_q <= ST_EXEC;
                    end
                end
                ST_ARG_WAIT:
                    state_q <= ST_ARG_CAP;
                ST_ARG_CAP:
                begin
                    arg_q <= pm_data_in;
                    state_q <= ST_EXEC;
                end
                ST_EXEC:
                begin
                    if (mc_tick && cyc_left_q != 2'd1)
                        cyc_left_q <= cyc_left_q - 2'd1;
                    if (exec_last)
                    begin
                        pc_q <= pc_next;
                        instr_done_out <= 1'b1;
                        if (run_q)
                        begin
                            pm_addr_out <= pc_next;
                            pm_rd_out <= 1'b1;
                            state_q <= ST_OP_WAIT;
                        end
                        else
                            state_q <= ST_IDLE;
                    end
                end
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // activity counters

    // completed instructions and machine cycles spent executing
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            instr_cnt_q <= '0;
            cycle_cnt_q <= '0;
        end
        else if (ce_in)
        begin
            if (exec_last)
                instr_cnt_q <= instr_cnt_q + 1'b1;
            if (mc_tick && state_q != ST_IDLE)
                cycle_cnt_q <= cycle_cnt_q + 1'b1;
        end
    end
endmodule // itd_core

// file: rtl/itd_pkg.sv
// package: constants, register map and instruction classes of the timing decoder
package itd_pkg;
    // clock and machine cycle timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int MACHINE_CYCLE_NS = 2500;
    localparam int MACHINE_CYCLE_CLKS = (MACHINE_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // widths
    localparam int PC_W = 12;
    localparam int AXI_AW = 8;
    localparam int AXI_DW = 32;
    localparam int CNT_W = 32;
    // register byte offsets
    localparam logic [AXI_AW-1:0] REG_CTRL = 8'h00;
    localparam logic [AXI_AW-1:0] REG_PC = 8'h04;
    localparam logic [AXI_AW-1:0] REG_STATUS = 8'h08;
    localparam logic [AXI_AW-1:0] REG_LAST = 8'h0C;
    localparam logic [AXI_AW-1:0] REG_INSTR_CNT = 8'h10;
    localparam logic [AXI_AW-1:0] REG_CYCLE_CNT = 8'h14;
    // field positions
    localparam int CTRL_RUN_BIT = 0;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_ILLEGAL_BIT = 1;
    localparam int STAT_TWO_BYTES_BIT = 2;
    localparam int STAT_TWO_CYCLES_BIT = 3;
    localparam int STAT_CLASS_LSB = 8;
    localparam int LAST_ARG_LSB = 8;
    // reset values
    localparam logic [PC_W-1:0] PC_RESET = 12'h000;
    localparam logic RUN_RESET = 1'b0;
    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // instruction classes, held in opcode bits 7..3; bits 2..0 pick register, bit, port or variant
    typedef enum logic [4:0] {
        CL_NOP = 5'h00, CL_ALU_REG = 5'h01, CL_ALU_IND = 5'h02, CL_ALU_IMM = 5'h03,
        CL_ACC_UNARY = 5'h04, CL_PORT_XFER = 5'h05, CL_PORT_IMM = 5'h06, CL_BUS_XFER = 5'h07,
        CL_BUS_IMM = 5'h08, CL_EXPANDER = 5'h09, CL_REG_INCDEC = 5'h0A, CL_IND_INC = 5'h0B,
        CL_JUMP_COND = 5'h0C, CL_DEC_BRANCH = 5'h0D, CL_JUMP = 5'h0E, CL_JUMP_IND = 5'h0F,
        CL_CALL = 5'h10, CL_RETURN = 5'h11, CL_MOVE = 5'h12, CL_MOV_IMM = 5'h13,
        CL_MOV_IMM_IND = 5'h14, CL_EXT_MOVE = 5'h15, CL_TABLE_READ = 5'h16, CL_TIMER = 5'h17,
        CL_INT_CTRL = 5'h18, CL_BANK_SEL = 5'h19, CL_CLK_OUT = 5'h1A, CL_FLAGS = 5'h1B,
        CL_UNDEF = 5'h1F
    } itd_class_t;
    // core sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000, ST_OP_WAIT = 3'b001, ST_OP_CAP = 3'b010, ST_DECODE = 3'b011,
        ST_ARG_WAIT = 3'b100, ST_ARG_CAP = 3'b101, ST_EXEC = 3'b110
    } itd_state_t;
endpackage

// file: rtl/itd_dec_if.sv
// interface: opcode to decoder and instruction timing back to the core
`timescale 1ns/1ps
interface itd_dec_if;
    import itd_pkg::*;
    logic [7:0] opcode;
    logic two_bytes;
    logic two_cycles;
    logic defined;
    itd_class_t cls;
    modport core (output opcode, input two_bytes, input two_cycles, input defined, input cls);
    modport dec (input opcode, output two_bytes, output two_cycles, output defined, output cls);
endinterface

// file: rtl/itd_decoder.sv
// module: maps an opcode to its class, encoded length and machine cycle count
`timescale 1ns/1ps
module itd_decoder
(
    // decode port
    itd_dec_if.dec dec
);
    import itd_pkg::*;

    // class field of the opcode; unused codes fall to undefined
    function automatic logic [2:0] timing_of(input logic [4:0] cf);
        // returns {defined, two_bytes, two_cycles}
        case (cf)
            CL_ALU_REG, CL_ALU_IND: timing_of = 3'h4;
            CL_ALU_IMM: timing_of = 3'h7;
            CL_ACC_UNARY: timing_of = 3'h4;
            CL_PORT_XFER: timing_of = 3'h5;
            CL_PORT_IMM: timing_of = 3'h7;
            CL_BUS_XFER: timing_of = 3'h5;
            CL_BUS_IMM: timing_of = 3'h7;
            CL_EXPANDER: timing_of = 3'h5;
            CL_REG_INCDEC, CL_IND_INC: timing_of = 3'h4;
            CL_JUMP_COND: timing_of = 3'h7;
            CL_DEC_BRANCH, CL_JUMP: timing_of = 3'h7;
            CL_JUMP_IND: timing_of = 3'h5;
            CL_CALL: timing_of = 3'h7;
            CL_RETURN: timing_of = 3'h5;
            CL_MOVE: timing_of = 3'h4;
            CL_MOV_IMM, CL_MOV_IMM_IND: timing_of = 3'h7;
            CL_EXT_MOVE: timing_of = 3'h5;
            CL_TABLE_READ: timing_of = 3'h5;
            CL_TIMER: timing_of = 3'h4;
            CL_INT_CTRL: timing_of = 3'h4;
            CL_BANK_SEL: timing_of = 3'h4;
            CL_CLK_OUT, CL_NOP, CL_FLAGS: timing_of = 3'h4;
            default: timing_of = 3'h0;
        endcase
    endfunction

    // one opcode per class and variant, no overlap between classes
    wire [4:0] class_field = dec.opcode[7:3];
    wire [2:0] timing = timing_of(class_field);

    // timing outputs; undefined opcodes run as one byte, one cycle
    assign dec.defined = timing[2];
    assign dec.two_bytes = timing[1];
    assign dec.two_cycles = timing[0];
    assign dec.cls = timing[2] ? itd_class_t'(class_field) : CL_UNDEF;
endmodule // itd_decoder

// file: rtl/itd_mc_timer.sv
// module: machine cycle tick generator
`timescale 1ns/1ps
module itd_mc_timer
#(
    parameter int CYCLE_CLKS = itd_pkg::MACHINE_CYCLE_CLKS
)
(
    // clock and control
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    // tick marking the start of each machine cycle
    output logic tick_out
);
    import itd_pkg::*;

    localparam int CW = $clog2(CYCLE_CLKS + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLE_CLKS - 1);

    logic [CW-1:0] cnt_q;

    // free-running divider, one tick per machine cycle
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            cnt_q <= '0;
            tick_out <= 1'b0;
        end
        else if (ce_in)
        begin
            cnt_q <= (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
            tick_out <= (cnt_q == LAST);
        end
    end
endmodule // itd_mc_timer

// file: test/itd_pm_model.sv
// model: program memory with one clock read latency
`timescale 1ns/1ps
module itd_pm_model
(
    // clock and read request
    input wire logic clk_in,
    input wire logic [itd_pkg::PC_W-1:0] pm_addr_in,
    input wire logic pm_rd_in,
    // read data
    output logic [7:0] pm_data_out = 8'h00
);
    logic [7:0] mem [0:4095];
    // unused locations hold the no-operation code
    initial
    begin
        foreach (mem[i]) mem[i] = 8'h00;
    end
    // read registered on the strobe; inverted on each later clock, so stale data matches the read value again every second clock
    always_ff @(posedge clk_in)
    begin
        pm_data_out <= pm_rd_in ? mem[pm_addr_in] : ~pm_data_out;
    end
endmodule // itd_pm_model

// file: test/itd_core_assertions.sv
// checker: fetch, completion and register bus properties of the core
`timescale 1ns/1ps
module itd_core_assertions
#(
    parameter int CYCLE_CLKS = 8
)
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // register bus
    input wire logic s_axi_awvalid_in,
    input wire logic s_axi_awready_out,
    input wire logic s_axi_wvalid_in,
    input wire logic s_axi_wready_out,
    input wire logic [1:0] s_axi_bresp_out,
    input wire logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic s_axi_arvalid_in,
    input wire logic s_axi_arready_out,
    input wire logic [31:0] s_axi_rdata_out,
    input wire logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    // program memory and completion
    input wire logic [11:0] pm_addr_out,
    input wire logic pm_rd_out,
    input wire logic instr_done_out
);
    logic [15:0] gap_q;
    logic seen_q;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    // clocks since the last completion; 16 bits, wraps at 65536, a multiple of power-of-two cycle lengths only
    always_ff @(posedge clk_in)
    begin
        gap_q <= (!rst_n_in || instr_done_out) ? 16'h0000 : gap_q + 16'h0001;
        seen_q <= rst_n_in && (seen_q || instr_done_out);
    end
    sequence s_two_fetch;
        pm_rd_out ##3 pm_rd_out;
    endsequence
    sequence s_write_taken;
        s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
    endsequence
    a_done_one_clock: assert property (instr_done_out |=> !instr_done_out)
        else $error("completion too long");
    a_done_on_tick: assert property (instr_done_out && seen_q |-> (gap_q + 16'h0001) % CYCLE_CLKS == 0)
        else $error("completion off cycle boundary");
    a_second_byte_addr: assert property (s_two_fetch |-> pm_addr_out == $past(pm_addr_out, 3) + 12'h001)
        else $error("second byte address wrong");
    a_fetch_one_clock: assert property (pm_rd_out |=> !pm_rd_out)
        else $error("fetch strobe too long");
    a_write_answer: assert property (s_write_taken |=> !s_axi_bvalid_out ##1 s_axi_bvalid_out)
        else $error("write response timing wrong");
    a_bresp_stands: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
        else $error("write response dropped");
    a_read_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out && !s_axi_arready_out)
        else $error("read answer late");
    a_rdata_stands: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
        else $error("read data dropped");
endmodule // itd_core_assertions

bind itd_core itd_core_assertions #(.CYCLE_CLKS(CYCLE_CLKS)) i_itd_core_assertions (.clk_in, .rst_n_in,
    .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out,
    .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out,
    .s_axi_rvalid_out, .s_axi_rready_in, .pm_addr_out, .pm_rd_out, .instr_done_out);

// file: test/testbench.sv
// testbench: runs every instruction class through the core and checks length and timing
`timescale 1ns/1ps
module testbench;
    import itd_pkg::*;
    localparam int CC = 16;
    localparam logic [28:0] TWO_B = 29'h0197148;
    localparam logic [28:0] TWO_C = 29'h07BF3E8;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [AXI_AW-1:0] addr = 8'h00;
    logic [AXI_DW-1:0] wdata = 32'h0, rd, rdata;
    logic [1:0] resp, bresp, rresp;
    logic awready, wready, bvalid, arready, rvalid, done, pm_rd;
    logic [PC_W-1:0] pm_addr, pc;
    logic [7:0] pm_data;
    int err_count = 0;
    int total_checks = 0;
    int n;
    time t;
    itd_core #(.CYCLE_CLKS(CC)) i_itd_core (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(1'b1),
        .s_axi_awaddr_in(addr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
        .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
        .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready), .s_axi_araddr_in(addr), .s_axi_arvalid_in(arvalid),
        .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
        .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .pm_addr_out(pm_addr), .pm_rd_out(pm_rd),
        .pm_data_in(pm_data), .instr_done_out(done));
    itd_pm_model i_itd_pm_model (.clk_in(clk_in), .pm_addr_in(pm_addr), .pm_rd_in(pm_rd), .pm_data_out(pm_data));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic stall(input string what);
        err_count++;
        $display("wrong value %s expected answer seen timeout", what);
        conclude();
    endtask
    // one register bus transfer; ready stands from the start until the answer is seen
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        logic ok;
        ok = 1'b0;
        addr <= a;
        wdata <= d;
        awvalid <= wr;
        wvalid <= wr;
        arvalid <= !wr;
        bready <= wr;
        rready <= !wr;
        for (int i = 0; i < 40 && !ok; i++)
        begin
            @(posedge clk_in);
            ok = wr ? (bvalid && bready) === 1'b1 : (rvalid && rready) === 1'b1;
            awvalid <= awvalid && !awready;
            wvalid <= wvalid && !wready;
            arvalid <= arvalid && !arready;
            bready <= bready && !ok;
            rready <= rready && !ok;
        end
        resp = wr ? bresp : rresp;
        rd = rdata;
        if (!ok)
            stall("bus");
        // one idle edge so the next call never reassigns a strobe in the same step
        @(posedge clk_in);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        forever #5 clk_in = ~clk_in;
    end
    // one instruction of each class, variant from the low bits, argument A0 plus index
    initial
    begin
        // program is loaded during reset, after the model has cleared its memory
        repeat (20) @(posedge clk_in);
        pc = 12'h010;
        for (n = 0; n < 29; n++)
        begin
            i_itd_pm_model.mem[pc] = {n[4:0], n[2:0]};
            i_itd_pm_model.mem[pc + 12'h001] = 8'hA0 + n[7:0];
            pc = pc + (TWO_B[n] ? 12'h002 : 12'h001);
        end
        i_itd_pm_model.mem[pc] = 8'h00;
        rst_n_in <= 1'b1;
        @(posedge clk_in);
        bus(1'b0, REG_PC, 32'h0);
        check("reset pc", 32'(PC_RESET), rd);
        bus(1'b0, REG_CTRL, 32'h0);
        check("reset run", 32'(RUN_RESET), rd);
        bus(1'b0, 8'h40, 32'h0);
        check("unmapped read", 32'(RESP_SLVERR), 32'(resp));
        bus(1'b1, 8'h40, 32'h0);
        check("unmapped write", 32'(RESP_SLVERR), 32'(resp));
        bus(1'b1, REG_PC, 32'h10);
        bus(1'b1, REG_CTRL, 32'h1);
        for (n = 0; n < 29; n++)
        begin
            // fetch strobe of instruction n marks the start of its first machine cycle
            for (int i = 0; i < 4 * CC && pm_rd !== 1'b1; i++) @(posedge clk_in);
            if (pm_rd !== 1'b1)
                stall("fetch");
            t = $time;
            // status and last word are read while instruction n executes, after its second byte
            repeat (4) @(posedge clk_in);
            bus(1'b0, REG_STATUS, 32'h0);
            check("bytes", 32'(TWO_B[n]), 32'(rd[STAT_TWO_BYTES_BIT]));
            check("cycles", 32'(TWO_C[n]), 32'(rd[STAT_TWO_CYCLES_BIT]));
            check("class", n < 28 ? n : 31, 32'(rd[12:8]));
            bus(1'b0, REG_LAST, 32'h0);
            check("last", {TWO_B[n] ? 8'hA0 + n[7:0] : 8'h00, n[4:0], n[2:0]}, 32'(rd[15:0]));
            if (n == 28)
                bus(1'b1, REG_CTRL, 32'h0);
            for (int i = 0; i < 4 * CC && done !== 1'b1; i++) @(posedge clk_in);
            if (done !== 1'b1)
                stall("completion");
            check("clocks", (TWO_C[n] ? 2 : 1) * CC, 32'(($time - t) / 10));
        end
        repeat (2 * CC) @(posedge clk_in);
        bus(1'b0, REG_PC, 32'h0);
        check("final pc", 32'(pc), rd);
        bus(1'b0, REG_STATUS, 32'h0);
        check("busy and illegal", 32'h2, rd & 32'h3);
        bus(1'b0, REG_INSTR_CNT, 32'h0);
        check("instructions", 32'h1D, rd);
        bus(1'b1, REG_STATUS, 32'h2);
        bus(1'b0, REG_STATUS, 32'h0);
        check("illegal cleared", 32'h0, rd & 32'h2);
        conclude();
    end
endmodule // testbench
